// ### verilog/bie_regs.vh
`ifndef BIE_REGS_VH
`define BIE_REGS_VH
// ----------------------------------------
// instruction encodings
// ----------------------------------------
`define BIE_OP_BRANCH_HI    13:11
`define BIE_OP_BRANCH_VAL   3'h5
`define BIE_OP_FILE_HI      13:8
`define BIE_OP_INCSKIP_VAL  6'h0F
`define BIE_OP_INC_VAL      6'h0A
`define BIE_LIT_FIELD       10:0
`define BIE_DEST_BIT        7
`define BIE_ADDR_FIELD      6:0
`define BIE_PAGE_FIELD      4:3
`define BIE_PAGE_LSB        11
`define BIE_NOP_WORD        14'h0000
// ----------------------------------------
// reset values
// ----------------------------------------
`define BIE_PC_RESET        13'h0000
`define BIE_BYTE_RESET      8'h00
`define BIE_ADDR_RESET      7'h00
`define BIE_ONE             8'h01
`endif

// ### verilog/bie_incr.v
`timescale 1ns/1ps
module bie_incr #(
  parameter WIDTH = 8
) (
  input  wire [WIDTH-1:0] value,
  output wire [WIDTH-1:0] sum,
  output wire             isZero
);
  // wraps at the maximum, zero test on the incremented result
  assign sum    = value + {{(WIDTH-1){1'b0}}, 1'b1};
  assign isZero = (sum == {WIDTH{1'b0}}); // see RULE7
endmodule // bie_incr

// ### verilog/bie_exec.v
`timescale 1ns/1ps
`include "bie_regs.vh"
// Behaviour
// RULE1: branch copies 11-bit literal into program counter bits 10 to 0.
// RULE2: branch fills counter bits 12 and 11 from page latch bits 4, 3.
// RULE3: branch is one word, two cycles, and leaves status flags alone.
// RULE4: increment-skip adds one to file reg; destination 0 writes work reg.
// RULE5: zero result discards prefetched word, runs no-operation, two cycles.
// RULE6: increment adds one in one cycle, writes back per d, updates zero.
// RULE7: skip test uses incremented result, so wrap to zero skips.
// RULE8: increment-skip never touches zero or other status flags.
module bie_exec #(
  parameter PCW = 13
) (
  input  wire          clk,
  input  wire          rstn,
  input  wire          instValid,
  input  wire [13:0]   instWord,
  input  wire [7:0]    fileData,
  input  wire [7:0]    pageLatch,
  input  wire          zeroIn,
  output reg  [PCW-1:0] pcLoad,
  output reg           pcLoadEn,
  output reg  [6:0]    fileAddr,
  output reg  [7:0]    fileWrData,
  output reg           fileWrEn,
  output reg  [7:0]    workData,
  output reg           workWrEn,
  output reg           zeroOut,
  output reg           zeroWrEn,
  output reg           flushFetch,
  output reg           busy
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_EXEC  = 2'b01;
  localparam ST_FLUSH = 2'b10;

  reg  [1:0] state;
  reg  [1:0] next_state;
  wire [7:0] incSum;
  wire       incZero;
  wire       isBranch;
  wire       isIncSkip;
  wire       isInc;
  wire       destFile;

  assign isBranch  = instValid &&
                     instWord[`BIE_OP_BRANCH_HI] == `BIE_OP_BRANCH_VAL;
  assign isIncSkip = instValid &&
                     instWord[`BIE_OP_FILE_HI] == `BIE_OP_INCSKIP_VAL;
  assign isInc     = instValid &&
                     instWord[`BIE_OP_FILE_HI] == `BIE_OP_INC_VAL;
  assign destFile  = instWord[`BIE_DEST_BIT];

  bie_incr #(
    .WIDTH (8)
  ) u_incr (
    .value  (fileData),
    .sum    (incSum),
    .isZero (incZero)
  );

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // second cycle of branch or skip is a no-operation slot; new words
  // presented in that slot are ignored, fetch unit must flush them
  always @* begin
    next_state = state;
    case (state)
      ST_EXEC: begin
        if (isBranch) begin
          next_state = ST_FLUSH; // see RULE3
        end else if (isIncSkip && incZero) begin
          next_state = ST_FLUSH; // see RULE5
        end
      end
      ST_FLUSH: begin
        next_state = ST_EXEC;
      end
      default: begin
        next_state = ST_EXEC;
      end
    endcase
  end

  // ----------------------------------------
  // execute, next values
  // ----------------------------------------
  // all decoding lands here so each output register below has one
  // plain source and stays a bare flip-flop at the port
  reg  [PCW-1:0] next_pcLoad;
  reg            next_pcLoadEn;
  reg  [6:0]     next_fileAddr;
  reg  [7:0]     next_fileWrData;
  reg            next_fileWrEn;
  reg  [7:0]     next_workData;
  reg            next_workWrEn;
  reg            next_zeroOut;
  reg            next_zeroWrEn;
  reg            next_flushFetch;
  reg            next_busy;
  wire [10:0]    branchLit;
  wire [1:0]     branchPage;
  wire           takeFile;

  assign branchLit  = instWord[`BIE_LIT_FIELD];   // see RULE1
  assign branchPage = pageLatch[`BIE_PAGE_FIELD]; // see RULE2
  assign takeFile   = isIncSkip || isInc;

  always @* begin
    next_pcLoad     = pcLoad;
    next_pcLoadEn   = 1'b0;
    next_fileAddr   = fileAddr;
    next_fileWrData = fileWrData;
    next_fileWrEn   = 1'b0;
    next_workData   = workData;
    next_workWrEn   = 1'b0;
    next_zeroOut    = zeroOut;
    next_zeroWrEn   = 1'b0;
    next_flushFetch = 1'b0;
    next_busy       = (next_state == ST_FLUSH); // see RULE3
    if (state == ST_EXEC) begin
      if (isBranch) begin
        next_pcLoad[`BIE_LIT_FIELD]      = branchLit;  // see RULE1
        next_pcLoad[PCW-1:`BIE_PAGE_LSB] = branchPage; // see RULE2
        next_pcLoadEn   = 1'b1;
        next_flushFetch = 1'b1; // see RULE3
      end else if (takeFile) begin
        next_fileAddr   = instWord[`BIE_ADDR_FIELD];
        next_fileWrData = incSum;
        next_workData   = incSum;
        next_fileWrEn   = destFile;  // see RULE6
        next_workWrEn   = !destFile; // see RULE4
        if (isInc) begin
          next_zeroOut  = incZero; // see RULE6
          next_zeroWrEn = 1'b1;
        end else begin
          // zero flag kept, only the skip acts on the result
          next_zeroOut    = zeroIn;  // see RULE8
          next_flushFetch = incZero; // see RULE5
        end
      end
    end
  end

  // ----------------------------------------
  // sequencer register
  // ----------------------------------------
  // busy mirrors the flush state so the fetch side sees it registered
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_EXEC;
      busy  <= 1'b0;
    end else begin
      state <= next_state;
      busy  <= next_busy;
    end
  end

  // ----------------------------------------
  // program counter load
  // ----------------------------------------
  // pcLoad keeps the last target; only the pulse tells the fetch unit
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pcLoad   <= `BIE_PC_RESET;
      pcLoadEn <= 1'b0;
    end else begin
      pcLoad   <= next_pcLoad;
      pcLoadEn <= next_pcLoadEn;
    end
  end

  // ----------------------------------------
  // file and work register write
  // ----------------------------------------
  // both data ports carry the sum; the enables pick the destination,
  // which saves a mux at the cost of one spare byte of flip-flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fileAddr   <= `BIE_ADDR_RESET;
      fileWrData <= `BIE_BYTE_RESET;
      fileWrEn   <= 1'b0;
      workData   <= `BIE_BYTE_RESET;
      workWrEn   <= 1'b0;
    end else begin
      fileAddr   <= next_fileAddr;
      fileWrData <= next_fileWrData;
      fileWrEn   <= next_fileWrEn;
      workData   <= next_workData;
      workWrEn   <= next_workWrEn;
    end
  end

  // ----------------------------------------
  // zero flag and fetch flush
  // ----------------------------------------
  // flush is a single pulse; the fetch unit must drop its word at once
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      zeroOut    <= 1'b0;
      zeroWrEn   <= 1'b0;
      flushFetch <= 1'b0;
    end else begin
      zeroOut    <= next_zeroOut;
      zeroWrEn   <= next_zeroWrEn;
      flushFetch <= next_flushFetch;
    end
  end
endmodule // bie_exec

// ### verif/bie_exec_monitor.sv
`timescale 1ns/1ps
module bie_exec_monitor #(parameter PCW = 13) (
  input wire           clk, rstn, instValid, pcLoadEn, workWrEn,
  input wire           zeroOut, zeroWrEn, flushFetch, busy,
  input wire [13:0]    instWord,
  input wire [7:0]     fileData, pageLatch, workData,
  input wire [PCW-1:0] pcLoad
);
  // refused words while busy never start anything
  wire tk  = instValid && !busy;
  wire br  = tk && instWord[13:11] == 3'h5;
  wire sk  = tk && instWord[13:8] == 6'h0F;
  wire inc = tk && instWord[13:8] == 6'h0A;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_branch_lit: assert property (br |=> pcLoadEn &&
    pcLoad[10:0] == $past(instWord[10:0])) else $error("bad literal");
  chk_branch_page: assert property (br |=>
    pcLoad[12:11] == $past(pageLatch[4:3])) else $error("bad page");
  chk_branch_two: assert property (br |=> flushFetch && busy &&
    !zeroWrEn ##1 !busy && !pcLoadEn) else $error("bad branch timing");
  chk_skip_work: assert property (sk && !instWord[7] |=>
    workWrEn && workData == $past(fileData) + 8'h01) else $error("bad w");
  chk_skip_wrap: assert property (sk && fileData == 8'hFF |=>
    flushFetch && busy ##1 !busy) else $error("no skip");
  chk_inc_zero: assert property (inc |=> zeroWrEn && !busy &&
    zeroOut == ($past(fileData) == 8'hFF)) else $error("bad zero");
  chk_skip_none: assert property (sk && fileData != 8'hFF |=>
    !flushFetch && !busy) else $error("false skip");
  chk_skip_flag: assert property (sk |=> !zeroWrEn)
    else $error("skip touched zero");
  cover property (br);
  cover property (sk ##1 busy);
  cover property (inc && fileData == 8'hFF);
endmodule // bie_exec_monitor
bind bie_exec bie_exec_monitor #(.PCW(PCW)) i_bie_exec_monitor (.*);

// ### verif/bie_exec_test.sv
`timescale 1ns/1ps
module bie_exec_test;
  reg         clk = 0, rstn = 0, instValid = 0, zeroIn = 0, fl;
  reg  [13:0] instWord = 14'h0000;
  reg  [7:0]  fileData = 8'h00, pageLatch = 8'h00, e;
  reg  [31:0] sd = 32'hA8D1;
  reg  [1:0]  k;
  wire [12:0] pcLoad;
  wire [6:0]  fileAddr;
  wire [7:0]  fileWrData, workData;
  wire        pcLoadEn, fileWrEn, workWrEn, zeroOut, zeroWrEn;
  wire        flushFetch, busy;
  integer     error_cnt = 0, checked = 0, i;
  always #50 clk = ~clk;
  bie_exec i_bie_exec (.*);
  function [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task chk(input string n, input logic [15:0] s, x);
    checked = checked + 1;
    if (s !== x) begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s exp %h seen %h", n, x, s);
    end
  endtask
  task summarize;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1;
    for (i = 0; i < 400; i = i + 1) begin
      sd = xs(sd);
      k = sd[1:0];
      // every eighth value forces the wrap to zero
      fileData = (i % 8 == 0) ? 8'hFF : sd[15:8];
      e = fileData + 8'h01;
      pageLatch = sd[23:16];
      zeroIn = sd[4];
      fl = k == 0 || (k == 1 && e == 8'h00);
      instWord = {k == 0 ? 3'h5 : 3'h0, sd[31:21]};
      if (k != 0) instWord[13:8] = k == 1 ? 6'h0F : k == 2 ? 6'h0A : 6'h3F;
      instValid = 1;
      @(negedge clk);
      if (k == 0) chk("pc", pcLoad, {pageLatch[4:3], instWord[10:0]});
      chk("pcEn", pcLoadEn, k == 0);
      chk("skip", {flushFetch, busy}, {fl, fl});
      chk("dest", {fileWrEn, workWrEn}, (k == 1 || k == 2) ?
        {instWord[7], !instWord[7]} : 2'h0);
      chk("zero", {zeroWrEn, k == 2 && zeroOut}, {k == 2, k == 2 && e == 0});
      if (k == 1) chk("keep", zeroOut, zeroIn);
      if (k == 1 || k == 2) chk("sum", {fileAddr, instWord[7] ? fileWrData :
        workData}, {instWord[6:0], e});
      if (fl) begin
        instWord = ~instWord;
        @(negedge clk);
        chk("dead", {pcLoadEn, fileWrEn, workWrEn, zeroWrEn, busy,
          flushFetch}, 0);
      end
    end
    $display("random test done");
    summarize;
  end
endmodule // bie_exec_test
